// ### verilog/lbr_pkg.sv
// Purpose: constants and state types of the break/parity/consistency receiver
// Assumes: 32-bit AXI4-Lite register access, one clock
// Notes:   register offsets are byte addresses
package lbr_pkg;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_DIV       = 8'h04;
  localparam logic [7:0]  OFS_STAT      = 8'h08;
  localparam logic [7:0]  OFS_TRIG      = 8'h0C;
  localparam logic [7:0]  OFS_TXD       = 8'h10;
  localparam logic [7:0]  OFS_RXD       = 8'h14;
  localparam int          CB_EN         = 0;
  localparam int          CB_TXE        = 1;
  localparam int          CB_RXE        = 2;
  localparam int          CB_DCS        = 3;
  localparam int          CB_MD0        = 4;
  localparam int          CB_MD1        = 5;
  localparam int          CB_PS0        = 6;
  localparam int          CB_PS1        = 7;
  localparam int          CB_CL         = 8;
  localparam int          CB_DIR        = 9;
  localparam int          CB_SL         = 10;
  localparam int          CB_RDL        = 11;
  localparam int          TB_BRT        = 0;
  localparam int          TB_BTT        = 1;
  localparam logic [11:0] CTRL_RST      = 12'h300;
  localparam logic [15:0] DIV_RST       = 16'h0010;
  localparam logic [15:0] DIV_MIN       = 16'h0004;
  localparam logic [1:0]  PAR_NONE      = 2'h0;
  localparam logic [1:0]  PAR_ZERO      = 2'h1;
  localparam logic [1:0]  PAR_ODD       = 2'h2;
  localparam logic [1:0]  PAR_EVEN      = 2'h3;
  localparam logic [4:0]  BRK_MIN_BITS  = 5'h0B;
  localparam logic [4:0]  BRK_TX_BITS   = 5'h0D;
  localparam logic [4:0]  LCNT_MAX      = 5'h1F;
  localparam logic [2:0]  CL8_LAST      = 3'h7;
  localparam logic [2:0]  CL7_LAST      = 3'h6;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP, R_BRK} lbr_rx_e;
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP1, T_STOP2, T_BRK} lbr_tx_e;
endpackage : lbr_pkg

// ### verilog/lbr_core.sv
// Purpose: break measurement, parity and tx/rx consistency checking unit
// Assumes: rx_pin synchronous to aclk, bit time set by divisor register
// Notes:   status_irq and rx_done_irq are one-cycle pulses
// Function
// - falling edge on rx starts low-period count until the rising edge
// - low period of eleven bits or more ends break normally
// - normal break in modes 10B and 11B sets break success flag with the status pulse, in other modes gives rx done pulse
// - successful break suppresses error checks and receive data store
// - low period under eleven bits fails break, sets errors, status pulse
// - consistency mismatch sets flag and status pulse, no rx done pulse
// - modes 10B and 11B recognise a break during communication
// - wait trigger sets wait flag, normal break clears it
// - even parity transmit bit is one for odd data ones count
// - even parity receive errors on odd total ones
// - odd parity transmit bit is zero for odd data ones count
// - odd parity receive errors on even total ones
// - zero parity sends zero bit and never checks it
// - no parity adds no bit and never reports error
// - consistency compare runs in every transmission, even with rx off
// - with rx on, early receive end during transmit is checked
// - consistency error drops pending tx data, break trigger, stops
// - receive data stored whether or not a consistency error occurred
// - compare start bit through first stop bit, never second stop
// - rx stop position during tx start, data, parity or break bits sets consistency error
`timescale 1ns/1ps
module lbr_core #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              rx_pin,
  output logic                   tx_pin,
  output logic                   status_irq,
  output logic                   rx_done_irq
);
  import lbr_pkg::*;

  if (ADDR_W < 5 || ADDR_W > 8) begin : g_chk
    $error("ADDR_W must be 5 to 8");
  end

  typedef struct packed {
    logic [11:0]       ctrl;
    logic [15:0]       div;
    logic              bsf;
    logic              ove;
    logic              pe;
    logic              fe;
    logic              dce;
    logic              brf;
    logic              rfull;
    logic [7:0]        rxd;
    logic              awg;
    logic              wg;
    logic [ADDR_W-1:0] awa;
    logic [31:0]       wd;
    logic [3:0]        ws;
    logic              bv;
    logic [1:0]        br;
    logic              rv;
    logic [31:0]       rd;
    logic [1:0]        rr;
    lbr_tx_e           ts;
    logic [15:0]       tph;
    logic [7:0]        tsh;
    logic [4:0]        tbi;
    logic              tpar;
    logic              txo;
    logic              tpend;
    logic [7:0]        tbuf;
    logic              bpend;
    lbr_rx_e           rs;
    logic [15:0]       rph;
    logic [7:0]        rsh;
    logic [2:0]        rbi;
    logic              rpar;
    logic [4:0]        lcnt;
    logic              rprev;
    logic              sirq;
    logic              dirq;
  } lbr_st_s;

  lbr_st_s q;
  lbr_st_s n;

  function automatic logic [31:0] smask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : smask

  // data masked to char length, reordered for msb-first
  function automatic logic [7:0] ord(input logic [7:0] d, input logic cl,
                                     input logic lsb);
    logic [7:0] m;
    logic [7:0] r;
    m = cl ? d : {1'b0, d[6:0]};
    for (int i = 0; i < 8; i++) begin
      r[i] = m[7-i];
    end
    if (!cl) begin
      r = {1'b0, r[7:1]};
    end
    return lsb ? m : r;
  endfunction : ord

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [31:0] m;
    logic [31:0] wv;
    logic [15:0] dv;
    logic [1:0]  ps;
    logic [2:0]  last;
    logic        rxs;
    logic        tend;
    logic        tmid;
    logic        rtick;
    logic        dcv;
    logic        stv;
    logic        perr;
    logic [4:0]  lnext;
    logic [7:0]  tdat;
    m = '0;
    wv = '0;
    n = q;
    n.sirq = 1'b0;
    n.dirq = 1'b0;
    dv = (q.div < DIV_MIN) ? DIV_MIN : q.div;
    ps = {q.ctrl[CB_PS1], q.ctrl[CB_PS0]};
    last = q.ctrl[CB_CL] ? CL8_LAST : CL7_LAST;
    rxs = rx_pin ^ q.ctrl[CB_RDL];
    tend = (q.tph == dv - 16'h0001);
    tmid = (q.tph == (dv >> 1));
    rtick = (q.rph == 16'h0000);
    dcv = 1'b0;
    stv = 1'b0;
    perr = 1'b0;
    lnext = rxs ? 5'h00 : ((q.lcnt == LCNT_MAX) ? q.lcnt : q.lcnt + 5'h01);
    tdat = ord(q.tbuf, q.ctrl[CB_CL], q.ctrl[CB_DIR]);

    // bus write
    if (awvalid && awready) begin
      n.awg = 1'b1;
      n.awa = awaddr;
    end
    if (wvalid && wready) begin
      n.wg = 1'b1;
      n.wd = wdata;
      n.ws = wstrb;
    end
    if (q.bv && bready) begin
      n.bv = 1'b0;
    end
    if (q.awg && q.wg && !q.bv) begin
      n.awg = 1'b0;
      n.wg = 1'b0;
      n.bv = 1'b1;
      n.br = RESP_OKAY;
      m = smask(q.ws);
      wv = q.wd & m;
      case (8'(q.awa))
        OFS_CTRL: n.ctrl = (q.ctrl & ~m[11:0]) | wv[11:0];
        OFS_DIV:  n.div = (q.div & ~m[15:0]) | wv[15:0];
        OFS_STAT: begin
          n.bsf = q.bsf & ~wv[0];
          n.ove = q.ove & ~wv[1];
          n.pe = q.pe & ~wv[2];
          n.fe = q.fe & ~wv[3];
          n.dce = q.dce & ~wv[4];
        end
        OFS_TRIG: begin
          if (wv[TB_BRT]) begin
            n.brf = 1'b1;
          end
          if (wv[TB_BTT] && !q.dce) begin
            n.bpend = 1'b1;
          end
        end
        OFS_TXD: begin
          if (m[0] && !q.dce) begin
            n.tbuf = wv[7:0];
            n.tpend = 1'b1;
          end
        end
        default: n.br = RESP_SLVERR;
      endcase
    end

    // bus read
    if (q.rv && rready) begin
      n.rv = 1'b0;
    end
    if (arvalid && arready) begin
      n.rv = 1'b1;
      n.rr = RESP_OKAY;
      n.rd = 32'h0000_0000;
      case (8'(araddr))
        OFS_CTRL: n.rd = {20'h0_0000, q.ctrl};
        OFS_DIV:  n.rd = {16'h0000, q.div};
        OFS_STAT: n.rd = {24'h00_0000, q.rs != R_IDLE, q.ts != T_IDLE, q.brf,
                          q.dce, q.fe, q.pe, q.ove, q.bsf};
        OFS_TRIG: n.rd = {30'h0000_0000, q.bpend, q.brf};
        OFS_TXD:  n.rd = {24'h00_0000, q.tbuf};
        OFS_RXD: begin
          n.rd = {24'h00_0000, q.rxd};
          n.rfull = 1'b0;
        end
        default: n.rr = RESP_SLVERR;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter
    if (q.ts != T_IDLE) begin
      n.tph = tend ? 16'h0000 : q.tph + 16'h0001;
    end
    if (q.ctrl[CB_DCS] && tmid && q.ts != T_IDLE && q.ts != T_STOP2
        && rxs != q.txo) begin
      dcv = 1'b1;
    end
    unique case (q.ts)
      T_IDLE: begin
        n.txo = 1'b1;
        n.tph = 16'h0000;
        if (q.ctrl[CB_TXE] && !q.dce) begin
          if (q.bpend) begin
            n.ts = T_BRK;
            n.txo = 1'b0;
            n.tbi = 5'h00;
            n.bpend = 1'b0;
          end else if (q.tpend) begin
            n.ts = T_START;
            n.txo = 1'b0;
            n.tsh = q.ctrl[CB_DIR] ? tdat : ord(tdat, q.ctrl[CB_CL], 1'b1);
            n.tsh = ord(q.tbuf, q.ctrl[CB_CL], 1'b1);
            if (!q.ctrl[CB_DIR]) begin
              n.tsh = tdat;
            end
            n.tpar = (ps == PAR_EVEN) ? ^tdat :
                     (ps == PAR_ODD) ? ~^tdat : 1'b0;
            n.tpend = 1'b0;
          end
        end
      end
      T_START: begin
        if (tend) begin
          n.ts = T_DATA;
          n.txo = q.tsh[0];
          n.tbi = 5'h00;
        end
      end
      T_DATA: begin
        if (tend) begin
          n.tsh = {1'b0, q.tsh[7:1]};
          if (q.tbi == {2'b00, last}) begin
            n.ts = (ps != PAR_NONE) ? T_PAR : T_STOP1;
            n.txo = (ps != PAR_NONE) ? q.tpar : 1'b1;
          end else begin
            n.txo = q.tsh[1];
            n.tbi = q.tbi + 5'h01;
          end
        end
      end
      T_PAR: begin
        if (tend) begin
          n.ts = T_STOP1;
          n.txo = 1'b1;
        end
      end
      T_STOP1: begin
        if (tend) begin
          n.ts = q.ctrl[CB_SL] ? T_STOP2 : T_IDLE;
        end
      end
      T_STOP2: begin
        if (tend) begin
          n.ts = T_IDLE;
        end
      end
      T_BRK: begin
        if (tend) begin
          if (q.tbi == BRK_TX_BITS - 5'h01) begin
            n.ts = T_STOP1;
            n.txo = 1'b1;
          end else begin
            n.tbi = q.tbi + 5'h01;
          end
        end
      end
    endcase

    ////////////////////////////////////////////////////////////////////////
    // receiver
    n.rprev = rxs;
    if (q.rs != R_IDLE) begin
      n.rph = rtick ? dv - 16'h0001 : q.rph - 16'h0001;
    end
    unique case (q.rs)
      R_IDLE: begin
        if (q.rprev && !rxs) begin
          n.rs = R_START;
          n.rph = dv >> 1;
          n.lcnt = 5'h00;
        end
      end
      R_START: begin
        if (rtick) begin
          n.rs = rxs ? R_IDLE : R_DATA;
          n.lcnt = lnext;
          n.rbi = 3'h0;
          n.rpar = 1'b0;
        end
      end
      R_DATA: begin
        if (rtick) begin
          n.rsh = {rxs, q.rsh[7:1]};
          n.rpar = q.rpar ^ rxs;
          n.lcnt = lnext;
          n.rbi = q.rbi + 3'h1;
          if (q.rbi == last) begin
            n.rs = (ps != PAR_NONE) ? R_PAR : R_STOP;
          end
        end
      end
      R_PAR: begin
        if (rtick) begin
          n.rpar = q.rpar ^ rxs;
          n.lcnt = lnext;
          n.rs = R_STOP;
        end
      end
      R_STOP: begin
        if (rtick) begin
          n.lcnt = lnext;
          if (q.ctrl[CB_TXE] && (q.ts == T_START || q.ts == T_DATA
              || q.ts == T_PAR || q.ts == T_BRK)) begin
            dcv = 1'b1;
          end
          n.rs = R_IDLE;
          if (rxs) begin
            perr = (ps == PAR_EVEN && q.rpar)
                   || (ps == PAR_ODD && !q.rpar);
            stv = !q.brf;
            if (stv && !q.dce && !dcv) begin
              n.dirq = 1'b1;
            end
          end else if (q.ctrl[CB_MD1] || q.brf) begin
            n.rs = R_BRK;
          end else begin
            n.fe = 1'b1;
            n.sirq = 1'b1;
            stv = 1'b1;
          end
        end
      end
      R_BRK: begin
        if (rtick) begin
          n.lcnt = lnext;
        end
        if (rxs) begin
          n.rs = R_IDLE;
          if (q.lcnt >= BRK_MIN_BITS) begin
            n.brf = 1'b0;
            if (q.ctrl[CB_MD1]) begin
              n.bsf = 1'b1;
              n.sirq = 1'b1;
            end else begin
              n.dirq = 1'b1;
            end
          end else begin
            n.fe = 1'b1;
            n.sirq = 1'b1;
            stv = !q.brf;
          end
        end
      end
    endcase
    if (stv) begin
      if (q.rfull && !(arvalid && arready && 8'(araddr) == OFS_RXD)) begin
        n.ove = 1'b1;
        n.sirq = 1'b1;
      end else begin
        n.rxd = ord(q.rsh >> (q.ctrl[CB_CL] ? 0 : 1), q.ctrl[CB_CL],
                    q.ctrl[CB_DIR]);
        n.rfull = 1'b1;
      end
    end
    if (perr) begin
      n.pe = 1'b1;
      n.sirq = 1'b1;
    end
    if (!q.ctrl[CB_RXE]) begin
      n.rs = R_IDLE;
    end

    // consistency error aborts transmission
    if (dcv) begin
      n.dce = 1'b1;
      n.sirq = 1'b1;
      n.ts = T_IDLE;
      n.txo = 1'b1;
      n.tpend = 1'b0;
      n.bpend = 1'b0;
    end

    // unit disable holds everything idle
    if (!q.ctrl[CB_EN]) begin
      n.ts = T_IDLE;
      n.rs = R_IDLE;
      n.txo = 1'b1;
      n.tpend = 1'b0;
      n.bpend = 1'b0;
      n.bsf = 1'b0;
      n.ove = 1'b0;
      n.pe = 1'b0;
      n.fe = 1'b0;
      n.dce = 1'b0;
      n.brf = 1'b0;
      n.rfull = 1'b0;
      n.sirq = 1'b0;
      n.dirq = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.div <= DIV_RST;
      q.txo <= 1'b1;
      q.rprev <= 1'b1;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign awready = !q.awg && !q.bv;
  assign wready = !q.wg && !q.bv;
  assign bvalid = q.bv;
  assign bresp = q.br;
  assign arready = !q.rv;
  assign rvalid = q.rv;
  assign rdata = q.rd;
  assign rresp = q.rr;
  assign tx_pin = q.txo;
  assign status_irq = q.sirq;
  assign rx_done_irq = q.dirq;
endmodule : lbr_core

// ### verif/lbr_core_props.sv
// Purpose: port-level checks of lbr_core
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every lbr_core instance
`timescale 1ns/1ps
module lbr_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic tx_pin,
  input wire logic status_irq,
  input wire logic rx_done_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_wr_take; awvalid && awready && wvalid && wready; endsequence
  sequence s_b_late; !bvalid ##1 bvalid; endsequence
  property p_b_lat; s_wr_take |=> s_b_late; endproperty
  property p_r_lat; arvalid && arready |=> rvalid; endproperty
  property p_b_drop; bvalid && bready |=> !bvalid; endproperty
  property p_r_drop; rvalid && rready |=> !rvalid; endproperty
  property p_w_block; bvalid |-> !awready && !wready; endproperty
  property p_ar_block; rvalid |-> !arready; endproperty
  property p_tx_idle; $rose(aresetn) |-> tx_pin; endproperty
  property p_st_pulse; status_irq |=> !status_irq; endproperty
  property p_rd_pulse; rx_done_irq |=> !rx_done_irq; endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  a_b_drop: assert property (p_b_drop) else $error("write answer held");
  a_r_drop: assert property (p_r_drop) else $error("read answer held");
  a_w_block: assert property (p_w_block) else $error("write taken while answering");
  a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
  a_tx_idle: assert property (p_tx_idle) else $error("line not idle after reset");
  a_st_pulse: assert property (p_st_pulse) else $error("status pulse too long");
  a_rd_pulse: assert property (p_rd_pulse) else $error("receive pulse too long");
endmodule : lbr_props

bind lbr_core lbr_props i_props (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .tx_pin(tx_pin),
  .status_irq(status_irq), .rx_done_irq(rx_done_irq));

// ### verif/lbr_node.sv
// Purpose: far bus node on a pulled-up single-wire line
// Assumes: called right after a rising clock edge
// Notes:   line is wired-and of both drivers
`timescale 1ns/1ps
module lbr_node (
  input  wire logic aclk,
  input  wire logic tx_pin,
  output logic      rx_pin
);
  logic drv = 1'b1;
  assign rx_pin = tx_pin & drv;
  // send n bits, first bit first, div clocks each
  task automatic send(input logic [15:0] bits, input int n, input int div);
    for (int i = 0; i < n; i++) begin
      drv <= bits[i];
      repeat (div) @(posedge aclk);
    end
    drv <= 1'b1;
  endtask : send
endmodule : lbr_node

// ### verif/break_rx_parity_consistency_tb.sv
// Purpose: self-checking bench for lbr_core
// Assumes: far node modelled by lbr_node
// Notes:   bit time shortened to DV clocks
`timescale 1ns/1ps
module break_rx_parity_consistency_tb;
  import lbr_pkg::*;
  localparam int DV = 8;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awready, wready, bvalid, arready, rvalid, tx_pin, rx_pin, status_irq, rx_done_irq;
  logic [1:0]  bresp, rresp, br, rr;
  logic [31:0] rdata, rd, base;
  logic [11:0] b;
  logic [15:0] f;
  logic [7:0]  d;
  int          n_mismatch = 0, total_checks = 0, seed = 59, cyc = 0, n_st = 0, n_rd = 0, k, j, lo;

  lbr_core #(.ADDR_W(8)) i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(1'b1), .rx_pin(rx_pin), .tx_pin(tx_pin), .status_irq(status_irq),
    .rx_done_irq(rx_done_irq));
  lbr_node i_node (.aclk(aclk), .tx_pin(tx_pin), .rx_pin(rx_pin));

  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (status_irq === 1'b1) n_st <= n_st + 1;
    if (rx_done_irq === 1'b1) n_rd <= n_rd + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit da = 1'b0;
    bit dw = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(da && dw)) begin
      @(posedge aclk);
      if (!da && awready === 1'b1) begin awvalid <= 1'b0; da = 1'b1; end
      if (!dw && wready === 1'b1) begin wvalid <= 1'b0; dw = 1'b1; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    br = bresp;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
  endtask : rd_reg
  function automatic logic par_bit(input logic [1:0] ps, input logic [7:0] v);
    if (ps == PAR_EVEN) return ^v;
    if (ps == PAR_ODD) return ~^v;
    return 1'b0;
  endfunction : par_bit
  // sample twelve bit centres of the next transmitted frame
  task automatic cap();
    do @(posedge aclk); while (tx_pin !== 1'b0);
    repeat (DV / 2 - 1) @(posedge aclk);
    for (int i = 0; i < 12; i++) begin
      b[i] = tx_pin;
      repeat (DV) @(posedge aclk);
    end
  endtask : cap
  // transmit v while the far node drives pattern pat from the start bit
  task automatic txc(input logic [7:0] v, input logic [15:0] pat, input int n);
    fork
      wr(OFS_TXD, {24'h0, v});
      begin
        do @(posedge aclk); while (tx_pin !== 1'b0);
        i_node.send(pat, n, DV);
      end
    join
  endtask : txc
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(OFS_CTRL);
    chk(rd, {20'h0, CTRL_RST});
    rd_reg(OFS_DIV);
    chk(rd, {16'h0, DIV_RST});
    wr(8'h3C, 32'h1);
    chk(br, RESP_SLVERR);
    rd_reg(8'h3C);
    chk({rr, rd[29:0]}, {RESP_SLVERR, 30'h0});
    wr(OFS_DIV, DV);
    base = 32'h1 << CB_EN | 32'h1 << CB_TXE | 32'h1 << CB_RXE | 32'h1 << CB_DCS
         | 32'h1 << CB_MD1 | 32'h1 << CB_CL | 32'h1 << CB_DIR;
    wr(OFS_CTRL, base);
    // break lengths: 11 waited, 10 and 13 during communication
    for (int i = 0; i < 3; i++) begin
      if (i == 0) begin
        wr(OFS_TRIG, 32'h1 << TB_BRT);
        rd_reg(OFS_TRIG);
        chk(rd[0], 1'b1);
      end
      k = n_st;
      i_node.send(16'h0000, i == 0 ? 11 : (i == 1 ? 10 : 13), DV);
      repeat (DV) @(posedge aclk);
      chk(n_st - k, 1);
      rd_reg(OFS_STAT);
      chk(rd[7:0], i == 1 ? 8'h08 : 8'h01);
      wr(OFS_STAT, 32'h1F);
      rd_reg(OFS_RXD);
      chk(rd[7:0], 8'h00);
    end
    // every parity code, on the line and on receive
    for (int p = 0; p < 4; p++) begin
      wr(OFS_CTRL, base | 32'(p) << CB_PS0);
      d = 8'($random(seed));
      fork
        wr(OFS_TXD, {24'h0, d});
        cap();
      join
      chk(b[8:0], {d, 1'b0});
      chk(b[10:9], {1'b1, p != 0 ? par_bit(2'(p), d) : 1'b1});
      rd_reg(OFS_RXD);
      chk(rd[7:0], d);
      for (int fl = 0; fl < 2; fl++) begin
        f = {7'h7F, 9'h000} | {7'h00, d, 1'b0};
        if (p != 0) f[9] = par_bit(2'(p), d) ^ 1'(fl);
        i_node.send(f, 11, DV);
        repeat (DV) @(posedge aclk);
        rd_reg(OFS_STAT);
        chk(rd[2], fl == 1 && p >= 2);
        rd_reg(OFS_RXD);
        chk(rd[7:0], d);
        wr(OFS_STAT, 32'h1F);
      end
    end
    // mismatch with receive off, then a dropped write
    wr(OFS_CTRL, base & ~(32'h1 << CB_RXE));
    k = n_st;
    j = n_rd;
    txc(8'hFF, 16'hFFFB, 4);
    wr(OFS_TXD, 32'h00);
    lo = 0;
    repeat (12 * DV) begin
      @(posedge aclk);
      if (tx_pin !== 1'b1) lo++;
    end
    chk(lo, 0);
    chk(n_st - k, 1);
    chk(n_rd - j, 0);
    rd_reg(OFS_STAT);
    chk(rd[6:4], 3'b001);
    wr(OFS_STAT, 32'h10);
    // first stop bit compared, second one not
    wr(OFS_CTRL, base & ~(32'h1 << CB_RXE) | 32'h1 << CB_SL);
    for (int s = 9; s < 11; s++) begin
      k = n_st;
      txc(8'hA5, ~(16'h1 << s), 11);
      repeat (2 * DV) @(posedge aclk);
      rd_reg(OFS_STAT);
      chk(rd[4], s == 9);
      chk(n_st - k, s == 9 ? 1 : 0);
      wr(OFS_STAT, 32'h1F);
    end
    // receive ends while own frame still going
    wr(OFS_CTRL, base);
    k = n_st;
    fork
      i_node.send(16'h03FE, 10, DV);
      begin
        repeat (2 * DV + DV / 2) @(posedge aclk);
        wr(OFS_TXD, 32'hFF);
      end
    join
    repeat (12 * DV) @(posedge aclk);
    chk(n_st - k, 1);
    rd_reg(OFS_STAT);
    chk(rd[4], 1'b1);
    rd_reg(OFS_RXD);
    chk(rd[7:0], 8'hFB);
    results();
  end
endmodule : break_rx_parity_consistency_tb
